// file: dpstat_pkg.sv
`default_nettype none
package dpstat_pkg;
    // =========================================================
    // register map
    localparam logic [7:0] DPSTAT_OPERATING_OFFSET = 8'h09;
    localparam logic [7:0] DPSTAT_PRIORITY_OFFSET  = 8'h0a;
    localparam logic [7:0] DPSTAT_OPERATING_RESET  = 8'h41;
    localparam logic [7:0] DPSTAT_PRIORITY_RESET   = 8'h00;

    // =========================================================
    // operating status field positions
    localparam int DPSTAT_AUX_LOCK_BIT   = 6;
    localparam int DPSTAT_MAIN_ALARM_BIT = 5;
    localparam int DPSTAT_AUX_ALARM_BIT  = 4;
    localparam int DPSTAT_MODE_LSB       = 0;
    localparam int DPSTAT_MODE_W         = 3;

    // priority status field positions
    localparam int DPSTAT_HIGHEST_LSB  = 4;
    localparam int DPSTAT_SELECTED_LSB = 0;
    localparam int DPSTAT_CHAN_W       = 4;

    // =========================================================
    // state machine operating mode codes
    localparam logic [2:0] DPSTAT_MODE_FREE_RUN    = 3'h1;
    localparam logic [2:0] DPSTAT_MODE_HOLDOVER    = 3'h2;
    localparam logic [2:0] DPSTAT_MODE_LOCKED      = 3'h4;
    localparam logic [2:0] DPSTAT_MODE_PRE_LOCKED2 = 3'h5;
    localparam logic [2:0] DPSTAT_MODE_PRE_LOCKED  = 3'h6;
    localparam logic [2:0] DPSTAT_MODE_PHASE_LOST  = 3'h7;
    localparam logic [2:0] DPSTAT_MODE_RESET       = 3'h1;

    // reference channel codes
    localparam logic [3:0] DPSTAT_CHAN_NONE = 4'h0;
    localparam logic [3:0] DPSTAT_CHAN_REF1 = 4'h3;
    localparam logic [3:0] DPSTAT_CHAN_REF2 = 4'h4;
    localparam logic [3:0] DPSTAT_CHAN_REF3 = 4'h8;
    localparam logic [3:0] DPSTAT_CHAN_REF4 = 4'h9;

    // =========================================================
    // carriers
    typedef struct packed {
        logic [2:0] main_dpll_state_code;
        logic       main_dpll_soft_alarm;
        logic       aux_dpll_soft_alarm;
        logic       aux_dpll_locked;
        logic [3:0] highest;
        logic [3:0] selected;
    } dpstat_snap_t;

    typedef struct packed {
        dpstat_snap_t snap;
        logic         main_limited;
        logic         aux_limited;
        logic [7:0]   rdata;
        logic         rd_valid;
    } dpstat_state_t;
endpackage
`default_nettype wire

// file: dpstat_regs.sv
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// R1: bit 5 of the operating status reads 1 while the main loop tracks beyond its soft limit.
// R2: bit 4 of the operating status reads 1 while the auxiliary loop tracks beyond its soft limit.
// R3: each loop has a hard limit where it stops following and a soft limit that raises the alarm.
// R4: bits 2..0 carry the main loop mode code, 001 free run to 111 phase lost, 000 and 011 unused.
// R5: priority status bits 7..4 give the highest priority validated input in channel code.
// R6: priority status bits 3..0 give the selected input in the same code, 0000 meaning none.
// R7: the priority fields describe the main path when the path select is 0, auxiliary when 1.
// R8: on the main path the selected input may differ from the highest validated one.
// R9: on the auxiliary path the selected input always equals the highest validated one.
// R10: both status registers are read only and writes change no field.
// R11: bit 6 reads 1 after reset and while the auxiliary loop is phase locked, and 0 otherwise.
// R12: a read returns live values sampled together so no field is seen half updated.
module dpstat_regs #(
    parameter int FREQ_W = 16                        // width of frequency offsets
) (
    input  wire logic              SYS_CLK,          // system clock, 25 MHz
    input  wire logic              RESET,            // async reset, active high
    input  wire logic [7:0]        REG_ADDR,         // register address
    input  wire logic              REG_RD,           // read strobe, one cycle
    input  wire logic              REG_WR,           // write strobe, ignored
    input  wire logic [7:0]        REG_WDATA,        // write data, ignored
    output logic      [7:0]        REG_RDATA,        // read data
    output logic                   REG_RD_VALID,     // read data valid pulse
    input  wire logic [2:0]        MAIN_STATE_CODE,  // main loop mode code
    input  wire logic              AUX_LOCKED,       // auxiliary loop phase locked
    input  wire logic [FREQ_W-1:0] MAIN_FREQ_DEV,    // main loop offset magnitude
    input  wire logic [FREQ_W-1:0] AUX_FREQ_DEV,     // auxiliary loop offset magnitude
    input  wire logic [FREQ_W-1:0] MAIN_SOFT_LIMIT,  // main soft alarm limit
    input  wire logic [FREQ_W-1:0] AUX_SOFT_LIMIT,   // auxiliary soft alarm limit
    input  wire logic [FREQ_W-1:0] MAIN_HARD_LIMIT,  // main tracking limit
    input  wire logic [FREQ_W-1:0] AUX_HARD_LIMIT,   // auxiliary tracking limit
    input  wire logic [3:0]        MAIN_HIGHEST,     // main path highest valid input
    input  wire logic [3:0]        MAIN_SELECTED,    // main path selected input
    input  wire logic [3:0]        AUX_HIGHEST,      // auxiliary path highest valid input
    input  wire logic              STATUS_PATH_SELECT, // 0 main path, 1 auxiliary path
    output logic                   MAIN_LIMITED,     // main loop stopped following
    output logic                   AUX_LIMITED       // auxiliary loop stopped following
);

    // =========================================================
    // decoding helpers

    // legal channel codes pass, anything else reads as none
    function automatic logic [3:0] chan_clean(input logic [3:0] code);
        logic [3:0] res;
        res = dpstat_pkg::DPSTAT_CHAN_NONE;
        unique case (code)
            dpstat_pkg::DPSTAT_CHAN_REF1,
            dpstat_pkg::DPSTAT_CHAN_REF2,
            dpstat_pkg::DPSTAT_CHAN_REF3,
            dpstat_pkg::DPSTAT_CHAN_REF4: res = code;
            default:                      res = dpstat_pkg::DPSTAT_CHAN_NONE;
        endcase
        return res;
    endfunction

    // true for a mode code that names a real state
    function automatic logic mode_legal(input logic [2:0] code);
        logic ok;
        ok = 1'b0;
        unique case (code)
            dpstat_pkg::DPSTAT_MODE_FREE_RUN,
            dpstat_pkg::DPSTAT_MODE_HOLDOVER,
            dpstat_pkg::DPSTAT_MODE_LOCKED,
            dpstat_pkg::DPSTAT_MODE_PRE_LOCKED2,
            dpstat_pkg::DPSTAT_MODE_PRE_LOCKED,
            dpstat_pkg::DPSTAT_MODE_PHASE_LOST: ok = 1'b1;
            default:                            ok = 1'b0;
        endcase
        return ok;
    endfunction

    // assemble the operating status byte
    function automatic logic [7:0] pack_operating(input dpstat_pkg::dpstat_snap_t s);
        logic [7:0] b;
        b = 8'h00;
        b[dpstat_pkg::DPSTAT_AUX_LOCK_BIT]   = s.aux_dpll_locked;      // see R11
        b[dpstat_pkg::DPSTAT_MAIN_ALARM_BIT] = s.main_dpll_soft_alarm; // see R1
        b[dpstat_pkg::DPSTAT_AUX_ALARM_BIT]  = s.aux_dpll_soft_alarm;  // see R2
        b[dpstat_pkg::DPSTAT_MODE_LSB +: dpstat_pkg::DPSTAT_MODE_W] =
            s.main_dpll_state_code;                                   // see R4
        return b;
    endfunction

    // assemble the priority status byte
    function automatic logic [7:0] pack_priority(input dpstat_pkg::dpstat_snap_t s);
        logic [7:0] b;
        b = 8'h00;
        b[dpstat_pkg::DPSTAT_HIGHEST_LSB +: dpstat_pkg::DPSTAT_CHAN_W]  = s.highest;  // see R5
        b[dpstat_pkg::DPSTAT_SELECTED_LSB +: dpstat_pkg::DPSTAT_CHAN_W] = s.selected; // see R6
        return b;
    endfunction

    // =========================================================
    // state

    dpstat_pkg::dpstat_state_t state_reg;
    dpstat_pkg::dpstat_state_t state_next;

    // =========================================================
    // next state

    always_comb begin
        state_next          = state_reg;
        state_next.rd_valid = 1'b0;

        // live snapshot taken every cycle as one word
        state_next.snap.main_dpll_soft_alarm = (MAIN_FREQ_DEV > MAIN_SOFT_LIMIT); // see R3
        state_next.snap.aux_dpll_soft_alarm  = (AUX_FREQ_DEV > AUX_SOFT_LIMIT);   // see R3
        state_next.main_limited              = (MAIN_FREQ_DEV > MAIN_HARD_LIMIT); // see R3
        state_next.aux_limited               = (AUX_FREQ_DEV > AUX_HARD_LIMIT);   // see R3
        state_next.snap.aux_dpll_locked      = AUX_LOCKED;                        // see R11

        // unused mode codes keep the last legal one
        if (mode_legal(MAIN_STATE_CODE)) begin
            state_next.snap.main_dpll_state_code = MAIN_STATE_CODE; // see R4
        end

        // path select steers the priority fields
        if (STATUS_PATH_SELECT) begin                                 // see R7
            state_next.snap.highest  = chan_clean(AUX_HIGHEST);
            state_next.snap.selected = chan_clean(AUX_HIGHEST);       // see R9
        end else begin
            state_next.snap.highest  = chan_clean(MAIN_HIGHEST);
            state_next.snap.selected = chan_clean(MAIN_SELECTED);     // see R8
        end

        // reads return the coherent snapshot, writes are dropped
        if (REG_RD) begin
            state_next.rd_valid = 1'b1;
            unique case (REG_ADDR)
                dpstat_pkg::DPSTAT_OPERATING_OFFSET:
                    state_next.rdata = pack_operating(state_reg.snap); // see R12
                dpstat_pkg::DPSTAT_PRIORITY_OFFSET:
                    state_next.rdata = pack_priority(state_reg.snap);  // see R12
                default:
                    state_next.rdata = 8'h00;
            endcase
        end
        // REG_WR and REG_WDATA feed nothing: see R10
    end

    // =========================================================
    // registers

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            state_reg                           <= '0;
            state_reg.snap.main_dpll_state_code <= dpstat_pkg::DPSTAT_MODE_RESET;
            state_reg.snap.aux_dpll_locked      <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // =========================================================
    // outputs straight from flip-flops

    assign REG_RDATA    = state_reg.rdata;
    assign REG_RD_VALID = state_reg.rd_valid;
    assign MAIN_LIMITED = state_reg.main_limited;
    assign AUX_LIMITED  = state_reg.aux_limited;

endmodule
`default_nettype wire

// file: dpstat_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// status port checks
module dpstat_checker #(
    parameter int FREQ_W = 16                // offset width
) (
    input wire logic              SYS_CLK,            // clock
    input wire logic              RESET,              // reset
    input wire logic [7:0]        REG_ADDR,           // address
    input wire logic              REG_RD,             // read
    input wire logic [7:0]        REG_RDATA,          // read data
    input wire logic              REG_RD_VALID,       // answer
    input wire logic [2:0]        MAIN_STATE_CODE,    // mode
    input wire logic              AUX_LOCKED,         // aux lock
    input wire logic [FREQ_W-1:0] MAIN_FREQ_DEV,      // main offset
    input wire logic [FREQ_W-1:0] AUX_FREQ_DEV,       // aux offset
    input wire logic [FREQ_W-1:0] MAIN_SOFT_LIMIT,    // main soft
    input wire logic [FREQ_W-1:0] AUX_SOFT_LIMIT,     // aux soft
    input wire logic [FREQ_W-1:0] MAIN_HARD_LIMIT,    // main hard
    input wire logic              MAIN_LIMITED,       // main limited
    input wire logic              STATUS_PATH_SELECT  // path
);
    logic live_reg;  // snapshot holds live inputs
    logic op_reg;    // operating read answered now
    logic pr_reg;    // priority read answered now
    // track reads that see live inputs
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            live_reg <= 1'b0;
            op_reg   <= 1'b0;
            pr_reg   <= 1'b0;
        end else begin
            live_reg <= 1'b1;
            op_reg   <= REG_RD && REG_ADDR == 8'h09 && live_reg;
            pr_reg   <= REG_RD && REG_ADDR == 8'h0a && live_reg;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    // ==========================================
    // assertions
    rd_answer_a: assert property (REG_RD |=> REG_RD_VALID)
        else $error("read not answered");
    answer_cause_a: assert property (REG_RD_VALID |-> $past(REG_RD))
        else $error("stray read answer");
    mode_field_a: assert property (op_reg && ($past(MAIN_STATE_CODE[2], 2)
        || ^$past(MAIN_STATE_CODE[1:0], 2)) |-> REG_RDATA[2:0] == $past(MAIN_STATE_CODE, 2))
        else $error("mode field wrong");
    aux_lock_a: assert property (op_reg |-> REG_RDATA[6] == $past(AUX_LOCKED, 2))
        else $error("lock bit wrong");
    main_alarm_a: assert property (op_reg |-> REG_RDATA[5] ==
        ($past(MAIN_FREQ_DEV, 2) > $past(MAIN_SOFT_LIMIT, 2))) else $error("main alarm wrong");
    aux_alarm_a: assert property (op_reg |-> REG_RDATA[4] ==
        ($past(AUX_FREQ_DEV, 2) > $past(AUX_SOFT_LIMIT, 2))) else $error("aux alarm wrong");
    hard_limit_a: assert property (live_reg |->
        MAIN_LIMITED == $past(MAIN_FREQ_DEV > MAIN_HARD_LIMIT)) else $error("limit wrong");
    aux_path_a: assert property (pr_reg && $past(STATUS_PATH_SELECT, 2) |->
        REG_RDATA[7:4] == REG_RDATA[3:0]) else $error("aux path fields differ");
endmodule
bind dpstat_regs dpstat_checker #(.FREQ_W(FREQ_W)) chk (.SYS_CLK, .RESET, .REG_ADDR,
    .REG_RD, .REG_RDATA, .REG_RD_VALID, .MAIN_STATE_CODE, .AUX_LOCKED, .MAIN_FREQ_DEV,
    .AUX_FREQ_DEV, .MAIN_SOFT_LIMIT, .AUX_SOFT_LIMIT, .MAIN_HARD_LIMIT, .MAIN_LIMITED,
    .STATUS_PATH_SELECT);
`default_nettype wire

// file: test_dpll_status_registers.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error %0t: got %h expected %h", $time, a, e); end end
// ==========================================
// bench top
module test_dpll_status_registers;
    logic        SYS_CLK, RESET, REG_RD, REG_WR, REG_RD_VALID, AUX_LOCKED;
    logic        STATUS_PATH_SELECT, MAIN_LIMITED, AUX_LIMITED;
    logic [2:0]  MAIN_STATE_CODE, lm;
    logic [3:0]  MAIN_HIGHEST, MAIN_SELECTED, AUX_HIGHEST;
    logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA;
    logic [15:0] MAIN_FREQ_DEV, AUX_FREQ_DEV, MAIN_SOFT_LIMIT, AUX_SOFT_LIMIT;
    logic [15:0] MAIN_HARD_LIMIT, AUX_HARD_LIMIT;
    logic [31:0] s = 32'h3f;
    logic [31:0] x;
    int          error_cnt, checks;
    logic [3:0]  chan [5] = '{4'h0, 4'h3, 4'h4, 4'h8, 4'h9};
    dpstat_regs dut (.SYS_CLK, .RESET, .REG_ADDR, .REG_RD, .REG_WR, .REG_WDATA, .REG_RDATA,
        .REG_RD_VALID, .MAIN_STATE_CODE, .AUX_LOCKED, .MAIN_FREQ_DEV, .AUX_FREQ_DEV,
        .MAIN_SOFT_LIMIT, .AUX_SOFT_LIMIT, .MAIN_HARD_LIMIT, .AUX_HARD_LIMIT, .MAIN_HIGHEST,
        .MAIN_SELECTED, .AUX_HIGHEST, .STATUS_PATH_SELECT, .MAIN_LIMITED, .AUX_LIMITED);
    // clock
    always #20 SYS_CLK = ~SYS_CLK;
    // xorshift source
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // expected byte for an address
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a == 8'h09) return {1'b0, AUX_LOCKED, MAIN_FREQ_DEV > MAIN_SOFT_LIMIT,
            AUX_FREQ_DEV > AUX_SOFT_LIMIT, 1'b0, lm};
        if (a == 8'h0a) return STATUS_PATH_SELECT ? {2{AUX_HIGHEST}}
            : {MAIN_HIGHEST, MAIN_SELECTED};
        return 8'h00;
    endfunction
    // one read, answer checked in its cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1;
        `CHK(REG_RD_VALID, 1'b1)
        `CHK(REG_RDATA, e)
        @(posedge SYS_CLK);
    endtask
    // verdict
    task automatic stop_test();
        if (error_cnt == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #120000;
        error_cnt++;
        stop_test();
    end
    // main sequence
    initial begin
        {SYS_CLK, REG_RD, REG_WR, AUX_LOCKED, STATUS_PATH_SELECT, MAIN_STATE_CODE} = '0;
        {MAIN_HIGHEST, MAIN_SELECTED, AUX_HIGHEST, REG_ADDR, REG_WDATA} = '0;
        {MAIN_FREQ_DEV, AUX_FREQ_DEV, MAIN_SOFT_LIMIT, AUX_SOFT_LIMIT} = '0;
        {MAIN_HARD_LIMIT, AUX_HARD_LIMIT} = '0;
        RESET = 1'b1;
        lm = 3'h1;
        repeat (5) @(posedge SYS_CLK);
        RESET <= 1'b0;
        rd(8'h09, 8'h41);
        repeat (200) begin
            x = xs();
            MAIN_STATE_CODE <= x[2:0];
            if (x[2] | ^x[1:0]) lm = x[2:0];
            AUX_LOCKED <= x[3];
            STATUS_PATH_SELECT <= x[4];
            REG_WR <= x[5];
            REG_WDATA <= x[15:8];
            MAIN_HIGHEST <= chan[x[18:16] % 3'h5];
            MAIN_SELECTED <= chan[x[21:19] % 3'h5];
            AUX_HIGHEST <= chan[x[24:22] % 3'h5];
            x = xs();
            MAIN_FREQ_DEV <= x[15:0];
            MAIN_SOFT_LIMIT <= x[15:0] + 16'(x[17:16]) - 16'h2;
            MAIN_HARD_LIMIT <= x[15:0] + 16'(x[19:18]) - 16'h2;
            AUX_FREQ_DEV <= x[31:16];
            AUX_SOFT_LIMIT <= x[31:16] + 16'(x[21:20]) - 16'h2;
            AUX_HARD_LIMIT <= x[31:16] + 16'(x[23:22]) - 16'h2;
            @(posedge SYS_CLK);
            rd(8'h09, exp_rd(8'h09));
            rd(8'h0a, exp_rd(8'h0a));
            rd(x[7:0], exp_rd(x[7:0]));
            `CHK(MAIN_LIMITED, MAIN_FREQ_DEV > MAIN_HARD_LIMIT)
            `CHK(AUX_LIMITED, AUX_FREQ_DEV > AUX_HARD_LIMIT)
        end
        // mid-run reset: first read sees the reset snapshot, later reads the live inputs
        RESET <= 1'b1;
        lm = 3'h1;
        if (MAIN_STATE_CODE[2] | ^MAIN_STATE_CODE[1:0]) lm = MAIN_STATE_CODE;
        repeat (5) @(posedge SYS_CLK);
        RESET <= 1'b0;
        rd(8'h09, 8'h41);
        rd(8'h09, exp_rd(8'h09));
        rd(8'h0a, exp_rd(8'h0a));
        stop_test();
    end
endmodule
`default_nettype wire
